//--- hdl/anb_bus_monitor.sv
// bus monitor: counts clocks of one cycle and flags a timeout
`timescale 1ns/100ps
`default_nettype none
module anb_bus_monitor
  import anb_pkg::*;
#(
  parameter int CNT_W = ANB_MON_W
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic run_i,
  input wire logic enable_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic expired_o
);
  logic [CNT_W-1:0] cnt_r;

  // counter restarts whenever no cycle is waiting
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I || !run_i)
      cnt_r <= '0;
    else if (cnt_r != limit_i)
      cnt_r <= cnt_r + 1'b1;
  end

  // a limit of zero never expires, so only the acknowledge can end the cycle
  assign expired_o = enable_i && run_i && (cnt_r == limit_i) && (limit_i != '0);
endmodule : anb_bus_monitor
`default_nettype wire

//--- hdl/anb_irq_unit.sv
// sticky event status with mask and one level interrupt
`timescale 1ns/100ps
`default_nettype none
module anb_irq_unit
  import anb_pkg::*;
#(
  parameter int EV_W = ANB_EV_W
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [EV_W-1:0] event_i,
  input wire logic clr_we_i,
  input wire logic mask_we_i,
  input wire logic [EV_W-1:0] wdata_i,
  output logic [EV_W-1:0] status_o,
  output logic [EV_W-1:0] mask_o,
  output logic irq_o
);
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      status_o <= '0;
    else
      status_o <= (status_o & ~(clr_we_i ? wdata_i : '0)) | event_i;
  end

  // mask register
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      mask_o <= '0;
    else if (mask_we_i)
      mask_o <= wdata_i;
  end

  assign irq_o = |(status_o & mask_o);
endmodule : anb_irq_unit
`default_nettype wire

//--- hdl/anb_master.sv
// non-burst external bus master with chip selects, wait states and bus monitor
//
// Behaviour
// R1 - first clock drives valid 28-bit address and transfer-type code
// R2 - access kind low in first clock (data), high in second (supervisor)
// R3 - longword write: read-not-write low, both width lines low in first clock
// R4 - begin strobe asserted in first clock, negated in second
// R5 - second clock asserts matching device select and drives write data
// R6 - peripheral captures write data and raises the done acknowledge
// R7 - acknowledge sampled end of second clock; select drops after next edge
// R8 - without acknowledge, insert wait states and keep sampling each edge
// R9 - enabled bus monitor timeout ends the cycle with internal bus error
// R10 - setup, no hold, no wait write never asserts byte write enables
// R11 - address setup option postpones device select for reads and writes
// R12 - auto-acknowledge inserts programmed wait clocks between first and second
// R13 - device select stays negated at least one clock between transfers
// R14 - idle: begin strobe, selects, write enables negated, data bus released
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module anb_master
  import anb_pkg::*;
#(
  parameter int ADDR_W = 28,
  parameter int DATA_W = 32,
  parameter int NCS = 4
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // register port
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  output logic IRQ_O,
  // external bus
  output logic [ADDR_W-1:0] ADDR_O,
  output logic [1:0] XFER_TYPE_O,
  output logic ACCESS_KIND_FLAG_O,
  output logic RD_NWR_O,
  output logic [1:0] XFER_WIDTH_O,
  output logic XFER_BEGIN_STROBE_N_O,
  output logic [NCS-1:0] DEV_SEL_N_O,
  output logic [3:0] WR_EN_N_O,
  output logic [DATA_W-1:0] DATA_O,
  output logic DATA_OE_N_O,
  input wire logic [DATA_W-1:0] DATA_I,
  input wire logic XFER_DONE_ACK_N_I
);
  // ****************************************
  // registers and state
  // ****************************************
  anb_state_e state_r;
  anb_state_e state_nxt;
  logic [31:0] ctrl_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic read_r;
  logic [1:0] width_r;
  logic pending_r;
  logic [ANB_WAIT_W-1:0] wcnt_r;
  logic [ANB_EV_W-1:0] status;
  logic [ANB_EV_W-1:0] mask;
  logic [ANB_EV_W-1:0] events;
  logic mon_expired;
  logic mon_run;
  logic ack_seen;
  logic sel_on;
  logic busy;

  wire logic setup_en = ctrl_r[ANB_CTRL_SETUP];
  wire logic auto_ack = ctrl_r[ANB_CTRL_AUTOACK];
  wire logic [ANB_WAIT_W-1:0] wait_cnt = ctrl_r[ANB_CTRL_WAIT_LSB +: ANB_WAIT_W];
  wire logic [ANB_CS_W-1:0] cs_idx = ctrl_r[ANB_CTRL_CS_LSB +: ANB_CS_W];
  wire logic [1:0] tt_code = ctrl_r[ANB_CTRL_TT_LSB +: 2];

  // byte lanes written for a given width and address
  function automatic logic [3:0] lanes(input logic [1:0] w, input logic [1:0] a);
    logic [3:0] l;
    l = 4'hf;
    case (w)
      ANB_WIDTH_BYTE: l = 4'h1 << a;
      ANB_WIDTH_WORD: l = a[1] ? 4'hc : 4'h3;
      default: l = 4'hf;
    endcase
    return l;
  endfunction : lanes

  // ****************************************
  // register writes
  // ****************************************
  wire logic wr_ctrl = REG_WR_I && (REG_ADDR_I == ANB_REG_CTRL);
  wire logic wr_cmd = REG_WR_I && (REG_ADDR_I == ANB_REG_CMD);
  assign busy = (state_r != ANB_IDLE) && (state_r != ANB_GAP);

  // control, address and data; held still while a cycle runs
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      ctrl_r <= ANB_CTRL_RST;
      addr_r <= '0;
      wdata_r <= '0;
    end
    else if (!pending_r && !busy)
    begin
      if (wr_ctrl)
        ctrl_r <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == ANB_REG_ADDR)
        addr_r <= REG_WDATA_I[ADDR_W-1:0];
      if (REG_WR_I && REG_ADDR_I == ANB_REG_WDATA)
        wdata_r <= REG_WDATA_I[DATA_W-1:0];
    end
  end

  // command write queues one transfer; ignored while one is outstanding
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      pending_r <= 1'b0;
      read_r <= 1'b0;
      width_r <= ANB_WIDTH_LONG;
    end
    else if (wr_cmd && !pending_r && !busy)
    begin
      pending_r <= 1'b1;
      read_r <= REG_WDATA_I[ANB_CMD_READ];
      width_r <= REG_WDATA_I[ANB_CMD_WIDTH_LSB +: 2];
    end
    else if (state_r == ANB_FIRST || state_r == ANB_SETUP)
      pending_r <= 1'b0;
  end

  // ****************************************
  // sequencer
  // ****************************************
  // acknowledge source: external pin or internal auto count
  assign ack_seen = auto_ack ? 1'b1 : !XFER_DONE_ACK_N_I;
  assign mon_run = (state_r == ANB_SECOND) && !auto_ack;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ANB_IDLE:
        if (pending_r)
          state_nxt = setup_en ? ANB_SETUP : ANB_FIRST;
      ANB_SETUP:
        state_nxt = ANB_FIRST;
      ANB_FIRST:
        if (auto_ack && wait_cnt != '0)
          state_nxt = ANB_WAITST; // R12
        else
          state_nxt = ANB_SECOND;
      ANB_WAITST:
        if (wcnt_r == '0)
          state_nxt = ANB_SECOND;
      ANB_SECOND:
        if (ack_seen || mon_expired)
          state_nxt = ANB_HOLD; // R7 R9
        else
          state_nxt = ANB_SECOND; // R8
      ANB_HOLD:
        state_nxt = ANB_GAP;
      ANB_GAP:
        state_nxt = ANB_IDLE; // R13
      default:
        state_nxt = ANB_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      state_r <= ANB_IDLE;
    else
      state_r <= state_nxt;
  end

  // wait clock counter loaded in the first clock
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      wcnt_r <= '0;
    else if (state_r == ANB_FIRST)
      wcnt_r <= wait_cnt - 1'b1; // R12
    else if (state_r == ANB_WAITST && wcnt_r != '0)
      wcnt_r <= wcnt_r - 1'b1;
  end

  anb_bus_monitor #(
    .CNT_W(ANB_MON_W)
  ) u_mon (
    .CORE_CLK_I(CORE_CLK_I),
    .RST_I(RST_I),
    .run_i(mon_run),
    .enable_i(ctrl_r[ANB_CTRL_MONEN]),
    .limit_i(ctrl_r[ANB_CTRL_MON_LSB +: ANB_MON_W]),
    .expired_o(mon_expired)
  );

  // read data captured when the acknowledge is seen
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      rdata_r <= '0;
    else if (state_r == ANB_SECOND && ack_seen && read_r)
      rdata_r <= DATA_I;
  end

  // ****************************************
  // bus pins
  // ****************************************
  // select runs from second clock through the edge after acknowledge
  // wait clocks sit before the second clock, so the select stays off through them
  assign sel_on = (state_r == ANB_SECOND) || (state_r == ANB_HOLD); // R5 R7 R11 R12

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      ADDR_O <= '0;
      XFER_TYPE_O <= 2'h0;
      RD_NWR_O <= 1'b1;
      XFER_WIDTH_O <= ANB_WIDTH_LONG;
    end
    else if (state_nxt == ANB_SETUP || (state_nxt == ANB_FIRST && state_r == ANB_IDLE))
    begin
      ADDR_O <= addr_r; // R1
      XFER_TYPE_O <= tt_code; // R1
      RD_NWR_O <= read_r; // R3
      XFER_WIDTH_O <= width_r; // R3
    end
  end

  // strobes: begin only in first clock, access kind high in wait and second clocks
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      XFER_BEGIN_STROBE_N_O <= 1'b1;
      ACCESS_KIND_FLAG_O <= 1'b0;
      DEV_SEL_N_O <= '1;
      WR_EN_N_O <= 4'hf;
      DATA_O <= '0;
      DATA_OE_N_O <= 1'b1;
    end
    else
    begin
      XFER_BEGIN_STROBE_N_O <= !(state_nxt == ANB_FIRST); // R4 R14
      ACCESS_KIND_FLAG_O <= (state_nxt == ANB_SECOND) || (state_nxt == ANB_WAITST); // R2
      DEV_SEL_N_O <= '1;
      if (state_nxt == ANB_SECOND || state_nxt == ANB_HOLD)
        DEV_SEL_N_O[cs_idx] <= 1'b0; // R5 R11 R13
      // with address setup and no waits the byte enables stay off
      if (!setup_en && !read_r && state_nxt == ANB_SECOND)
        WR_EN_N_O <= ~lanes(width_r, addr_r[1:0]);
      else
        WR_EN_N_O <= 4'hf; // R10 R14
      if (!read_r && (state_nxt == ANB_SECOND || state_nxt == ANB_WAITST ||
          state_nxt == ANB_HOLD))
      begin
        DATA_O <= wdata_r; // R5
        DATA_OE_N_O <= 1'b0;
      end
      else
        DATA_OE_N_O <= 1'b1; // R14
    end
  end

  // ****************************************
  // events and register read
  // ****************************************
  assign events[ANB_EV_DONE] = (state_r == ANB_SECOND) && ack_seen;
  assign events[ANB_EV_BERR] = (state_r == ANB_SECOND) && !ack_seen && mon_expired; // R9

  anb_irq_unit #(
    .EV_W(ANB_EV_W)
  ) u_irq (
    .CORE_CLK_I(CORE_CLK_I),
    .RST_I(RST_I),
    .event_i(events),
    .clr_we_i(REG_WR_I && REG_ADDR_I == ANB_REG_IRQ),
    .mask_we_i(REG_WR_I && REG_ADDR_I == ANB_REG_MASK),
    .wdata_i(REG_WDATA_I[ANB_EV_W-1:0]),
    .status_o(status),
    .mask_o(mask),
    .irq_o(IRQ_O)
  );

  // read data valid the cycle after the read strobe only
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I || !REG_RD_I)
      REG_RDATA_O <= ANB_ZERO;
    else
      case (REG_ADDR_I)
        ANB_REG_CTRL: REG_RDATA_O <= ctrl_r;
        ANB_REG_ADDR: REG_RDATA_O <= {{(32-ADDR_W){1'b0}}, addr_r};
        ANB_REG_WDATA: REG_RDATA_O <= wdata_r;
        ANB_REG_RDATA: REG_RDATA_O <= rdata_r;
        ANB_REG_STAT: REG_RDATA_O <= {29'h0, sel_on, pending_r, busy};
        ANB_REG_IRQ: REG_RDATA_O <= {30'h0, status};
        ANB_REG_MASK: REG_RDATA_O <= {30'h0, mask};
        default: REG_RDATA_O <= ANB_ZERO;
      endcase
  end

  // ****************************************
  // checks
  // ****************************************
  begin_one_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    !XFER_BEGIN_STROBE_N_O |=> XFER_BEGIN_STROBE_N_O) // R4
    else $error("begin strobe longer than one clock");
  kind_flag_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    !XFER_BEGIN_STROBE_N_O |-> !ACCESS_KIND_FLAG_O) // R2
    else $error("access kind high in first clock");
  sel_after_begin_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    $fell(XFER_BEGIN_STROBE_N_O) && (!auto_ack || wait_cnt == '0) |=> !(&DEV_SEL_N_O)) // R5
    else $error("select not asserted in second clock");
  wait_no_sel_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (state_r == ANB_WAITST) |-> (&DEV_SEL_N_O)) // R12
    else $error("select asserted during wait clocks");
  setup_delay_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (state_r == ANB_SETUP) |-> (&DEV_SEL_N_O) ##1 (&DEV_SEL_N_O)) // R11
    else $error("select not postponed under address setup");
  ack_end_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (state_r == ANB_SECOND) && ack_seen |=> !(&DEV_SEL_N_O) ##1 (&DEV_SEL_N_O)) // R7
    else $error("select not dropped after acknowledge");
  wait_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (state_r == ANB_SECOND) && !ack_seen && !mon_expired |=> state_r == ANB_SECOND) // R8
    else $error("cycle left without acknowledge");
  bus_err_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    events[ANB_EV_BERR] |=> status[ANB_EV_BERR] && state_r == ANB_HOLD) // R9
    else $error("timeout did not flag bus error");
  no_we_setup_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    setup_en |=> &WR_EN_N_O) // R10
    else $error("write enable under address setup");
  sel_gap_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    $rose(&DEV_SEL_N_O) |=> &DEV_SEL_N_O) // R13
    else $error("select reasserted without gap");
  idle_quiet_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    $past(state_r == ANB_IDLE && !pending_r) |-> XFER_BEGIN_STROBE_N_O && DATA_OE_N_O) // R14
    else $error("bus driven while idle");
endmodule : anb_master
`default_nettype wire

//--- inc/anb_pkg.sv
// constants and types shared by the non-burst external bus master
package anb_pkg;
  // transfer widths on the two width lines
  localparam logic [1:0] ANB_WIDTH_LONG = 2'h0;
  localparam logic [1:0] ANB_WIDTH_BYTE = 2'h1;
  localparam logic [1:0] ANB_WIDTH_WORD = 2'h2;
  // register indices on the plain register port
  localparam logic [3:0] ANB_REG_CTRL = 4'h0;
  localparam logic [3:0] ANB_REG_ADDR = 4'h1;
  localparam logic [3:0] ANB_REG_WDATA = 4'h2;
  localparam logic [3:0] ANB_REG_RDATA = 4'h3;
  localparam logic [3:0] ANB_REG_CMD = 4'h4;
  localparam logic [3:0] ANB_REG_STAT = 4'h5;
  localparam logic [3:0] ANB_REG_IRQ = 4'h6;
  localparam logic [3:0] ANB_REG_MASK = 4'h7;
  // control register fields
  localparam int ANB_CTRL_SETUP = 0;
  localparam int ANB_CTRL_AUTOACK = 1;
  localparam int ANB_CTRL_MONEN = 2;
  localparam int ANB_CTRL_WAIT_LSB = 4;
  localparam int ANB_CTRL_MON_LSB = 8;
  localparam int ANB_CTRL_CS_LSB = 16;
  localparam int ANB_CTRL_TT_LSB = 20;
  localparam int ANB_WAIT_W = 4;
  localparam int ANB_MON_W = 8;
  localparam int ANB_CS_W = 2;
  // command register fields
  localparam int ANB_CMD_READ = 0;
  localparam int ANB_CMD_WIDTH_LSB = 1;
  // event bits, shared by sticky status and mask
  localparam int ANB_EV_DONE = 0;
  localparam int ANB_EV_BERR = 1;
  localparam int ANB_EV_W = 2;
  // reset values
  localparam logic [31:0] ANB_CTRL_RST = 32'h0000ff04;
  localparam logic [31:0] ANB_ZERO = 32'h0;
  // timing in ns and derived cycles
  localparam int ANB_CLK_NS = 10;
  localparam int ANB_CS_GAP_NS = 10;
  localparam int ANB_CS_GAP_CYC = (ANB_CS_GAP_NS + ANB_CLK_NS - 1) / ANB_CLK_NS;
  // sequencer states
  typedef enum logic [2:0] {
    ANB_IDLE,
    ANB_SETUP,
    ANB_FIRST,
    ANB_WAITST,
    ANB_SECOND,
    ANB_HOLD,
    ANB_GAP
  } anb_state_e;
endpackage : anb_pkg

//--- tb/anb_periph_model.sv
// behavioural peripheral on the far side of the chip selects
`timescale 1ns/100ps
`default_nettype none
module anb_periph_model
(
  input wire logic clk_i,
  input wire logic [27:0] addr_i,
  input wire logic beg_n_i,
  input wire logic sel_n_i,
  input wire logic rd_nwr_i,
  input wire logic [31:0] data_i,
  input wire logic [7:0] delay_i,
  input wire logic mute_i,
  output logic ack_n_o,
  output logic [31:0] data_o,
  output logic [31:0] last_o
);
  // ****************************************
  // storage and answer
  // ****************************************
  logic [31:0] mem [0:255];
  logic [31:0] junk = 32'h5a5a5a5a;
  logic [27:0] a_r = 28'h0;
  int cnt = 0;
  // ack waits delay_i clocks; mute models a dead slave, idle ack rests at its pull-up
  assign ack_n_o = !(!sel_n_i && cnt >= delay_i && !mute_i);
  // undriven data toggles so a stale value never looks valid
  assign data_o = (!sel_n_i && rd_nwr_i) ? mem[a_r[7:0]] : junk;
  // latch address at begin, capture write data when acking
  always @(posedge clk_i)
  begin
    junk <= ~junk;
    cnt <= sel_n_i ? 0 : cnt + 1;
    if (!beg_n_i)
      a_r <= addr_i;
    if (!sel_n_i && !ack_n_o && !rd_nwr_i)
    begin
      mem[a_r[7:0]] <= data_i;
      last_o <= data_i;
    end
  end
endmodule : anb_periph_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the non-burst bus master
`timescale 1ns/100ps
`default_nettype none
module tb;
  import anb_pkg::*;
  // ****************************************
  // signals and expectations
  // ****************************************
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mute = 1'b0, active = 1'b0, seen = 1'b0;
  logic irq, rnw, kind, beg_n, oe_n, ack_n, e_rd, e_setup;
  logic [3:0] ra = 4'h0, sel_n, we_n, e_sel;
  logic [31:0] wd = 32'h0, rdat, dout, din, last_wr, e_data;
  logic [27:0] addr, e_addr, prev_addr;
  logic [1:0] tt, wid, e_tt, e_wid, idx;
  logic [7:0] dly = 8'h0;
  logic [31:0] model [0:255];
  int err_count = 0, tests_run = 0, seed = 13846, cyc = 0;
  int e_gap = 1, e_low = 0, since = 0, low_cnt = 0;
  anb_master u_anb_master (.CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(ra), .REG_WDATA_I(wd),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .IRQ_O(irq), .ADDR_O(addr),
    .XFER_TYPE_O(tt), .ACCESS_KIND_FLAG_O(kind), .RD_NWR_O(rnw), .XFER_WIDTH_O(wid),
    .XFER_BEGIN_STROBE_N_O(beg_n), .DEV_SEL_N_O(sel_n), .WR_EN_N_O(we_n), .DATA_O(dout),
    .DATA_OE_N_O(oe_n), .DATA_I(din), .XFER_DONE_ACK_N_I(ack_n));
  anb_periph_model u_anb_periph_model (.clk_i(clk), .addr_i(addr), .beg_n_i(beg_n),
    .sel_n_i(&sel_n), .rd_nwr_i(rnw), .data_i(dout), .delay_i(dly), .mute_i(mute),
    .ack_n_o(ack_n), .data_o(din), .last_o(last_wr));
  always #5 clk = ~clk;
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdat;
  endtask : rreg
  // poll busy and pending with a bounded count
  task automatic wait_idle;
    logic [31:0] s;
    int n;
    n = 0;
    do
    begin
      rreg(ANB_REG_STAT, s);
      n++;
    end
    while (s[1:0] !== 2'h0 && n < 200);
    chk(n < 200, "transfer never finished");
  endtask : wait_idle
  // modes: 0 ack, 1 slow ack, 2 auto-ack, 3 address setup, 4 dead slave
  task automatic xfer(input logic rdop, input logic [1:0] w, input int mode);
    logic [31:0] r;
    int wt;
    wt = (mode == 2) ? ($random(seed) & 15) : 0;
    e_setup = (mode == 3);
    e_rd = rdop;
    e_wid = w;
    e_gap = 1 + wt;
    e_low = (mode == 4) ? 0 : ((mode == 1) ? 5 : 2);
    dly <= (mode == 1) ? 8'h3 : 8'h0;
    mute <= (mode == 4);
    wreg(ANB_REG_CTRL, {10'h0, e_tt, 2'h0, idx, (mode == 4) ? 8'h06 : 8'hff, wt[3:0], 1'b0,
      1'b1, mode == 2, mode == 3});
    wreg(ANB_REG_ADDR, {4'h0, e_addr});
    wreg(ANB_REG_WDATA, e_data);
    active = 1'b1;
    wreg(ANB_REG_CMD, {29'h0, w, rdop});
    wait_idle();
    active = 1'b0;
    if (mode != 4 && w == ANB_WIDTH_LONG && rdop)
    begin
      rreg(ANB_REG_RDATA, r);
      chk(r === model[e_addr[7:0]], "read data differ");
    end
    if (mode != 4 && w == ANB_WIDTH_LONG && !rdop)
    begin
      model[e_addr[7:0]] = e_data;
      chk(last_wr === e_data, "peripheral got wrong data");
    end
  endtask : xfer
  // ****************************************
  // bus observer, cycle timeout, sequence
  // ****************************************
  // settled outputs are judged mid-cycle
  always @(negedge clk)
  begin
    if (!rst && beg_n === 1'b0)
    begin
      chk(addr === e_addr && tt === e_tt, "first clock address");
      chk(kind === 1'b0, "first clock kind");
      chk(rnw === e_rd && wid === e_wid, "first clock direction");
      chk(sel_n === 4'hf, "select early");
      if (e_setup)
        chk(prev_addr === e_addr, "no setup clock");
      since = 0;
      seen = 1'b1;
    end
    else if (seen)
      since++;
    if (seen && sel_n !== 4'hf)
    begin
      chk(since === e_gap, "select delay");
      chk(sel_n === e_sel && kind === 1'b1 && beg_n === 1'b1, "second clock");
      if (!e_rd && e_wid == ANB_WIDTH_LONG)
        chk(dout === e_data && oe_n === 1'b0, "write data");
      if (!e_rd && e_wid == ANB_WIDTH_LONG && !e_setup)
        chk(we_n === 4'h0, "longword write enables");
      seen = 1'b0;
      low_cnt = 0;
    end
    if (sel_n !== 4'hf)
      low_cnt++;
    else if (low_cnt > 0)
    begin
      if (e_low > 0)
        chk(low_cnt === e_low, "select length");
      low_cnt = 0;
    end
    if (e_setup && active)
      chk(we_n === 4'hf, "write enable in setup");
    if (!active && !rst)
      chk(beg_n === 1'b1 && sel_n === 4'hf && we_n === 4'hf && oe_n === 1'b1, "idle");
    prev_addr = addr;
  end
  // ceiling far above the several hundred clocks the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_count++;
      $display("MISMATCH %0t timeout", $time);
      stop_test();
    end
  end
  initial
  begin
    logic [31:0] r;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rreg(ANB_REG_CTRL, r);
    chk(r === ANB_CTRL_RST, "ctrl reset");
    rreg(ANB_REG_MASK, r);
    chk(r === ANB_ZERO, "mask reset");
    rreg(4'h9, r);
    chk(r === ANB_ZERO, "unmapped read");
    for (int i = 0; i < 12; i++)
    begin
      e_addr = $random(seed);
      e_data = $random(seed);
      e_tt = $random(seed);
      idx = $random(seed);
      e_sel = ~(4'h1 << idx);
      xfer(1'b0, 2'(i % 3), i % 4);
      xfer(1'b1, 2'(i % 3), i % 4);
    end
    rreg(ANB_REG_IRQ, r);
    chk(r[ANB_EV_DONE] === 1'b1, "done event");
    xfer(1'b1, ANB_WIDTH_LONG, 4);
    rreg(ANB_REG_IRQ, r);
    chk(r[ANB_EV_BERR] === 1'b1, "bus error event");
    wreg(ANB_REG_MASK, 32'h2);
    @(negedge clk);
    chk(irq === 1'b1, "irq unmasked");
    wreg(ANB_REG_MASK, 32'h0);
    @(negedge clk);
    chk(irq === 1'b0, "irq masked");
    wreg(ANB_REG_IRQ, 32'h3);
    rreg(ANB_REG_IRQ, r);
    chk(r === ANB_ZERO, "status cleared");
    stop_test();
  end
endmodule : tb
`default_nettype wire
